// file: design/ffsf_pkg.sv
package ffsf_pkg;

  // Fixed organisation: smallest documented depth
  localparam int unsigned PTR_W      = 11;
  localparam logic [10:0] DEPTH      = 11'h400;
  localparam logic [10:0] HALF_DEPTH = 11'h200;
  localparam logic [10:0] ONE_WORD   = 11'h001;

  // Offset defaults after master reset (plain values)
  localparam logic [10:0] FULL_OFS_RST  = 11'h07F;
  localparam logic [10:0] EMPTY_OFS_RST = 11'h07F;

  // Register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0]  REG_FULL_OFS  = 4'h0;
  localparam logic [3:0]  REG_EMPTY_OFS = 4'h4;
  localparam logic [3:0]  REG_STATUS    = 4'h8;
  localparam logic [3:0]  REG_LEVEL     = 4'hC;

  // Status register field positions
  localparam int unsigned ST_NO_ROOM     = 0;
  localparam int unsigned ST_NOTHING     = 1;
  localparam int unsigned ST_ALMOST_FULL = 2;
  localparam int unsigned ST_ALMOST_EMPT = 3;
  localparam int unsigned ST_HALF        = 4;
  localparam int unsigned ST_FT_MODE     = 5;
  localparam int unsigned ST_SYNC_TIMING = 6;
  localparam int unsigned ST_OUT_VALID   = 7;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ffsf_bus_t;

  typedef logic [PTR_W-1:0] ffsf_ptr_t;

endpackage

// file: design/ffsf_status_flags.sv
// Contract
// RULE1: Standard mode: no_room_n low while full, high otherwise.
// RULE2: Standard mode, no reads: no_room_n asserts after exactly depth writes.
// RULE3: Fall-through: accept_ready_n low while space is free, high when none.
// RULE4: Fall-through, no reads: accept_ready_n rises after depth plus one writes.
// RULE5: Fall-through fill count includes the word held in the output register.
// RULE6: Full/ready output updates on write ticks through a two-stage chain; the code uses three (rdSync1_q, rdSync2_q, flag).
// RULE7: Standard mode: nothing_stored_n low while empty, reads blocked then.
// RULE8: Fall-through: data_shown_n falls when the first word becomes valid.
// RULE9: data_shown_n rises only on a read tick with read enable low.
// RULE10: Empty/shown flag on read ticks: two stages standard, three fall-through.
// RULE11: Standard mode: almost_full_n low after depth minus m writes.
// RULE12: Fall-through: almost_full_n low after depth plus one minus m writes.
// RULE13: Async timing: almost_full_n set on write, released on read tick.
// RULE14: Standard mode: almost_empty_n low with n words or fewer.
// RULE15: Fall-through: almost_empty_n low with n+1 words or fewer.
// RULE16: Async timing: almost_empty_n set on read, released on write tick.
// RULE17: half_level_n falls on write above half, rises on read at half.
// RULE18: Standard mode, no reads: half_level_n falls after half depth plus one writes.
// RULE19: Fall-through, no reads: half_level_n falls after (D-1)/2 plus two writes.
// RULE20: Write enable is ignored while the FIFO is full, both modes.
// RULE21: Fall-through: first word shows on the third read tick after the write.
// RULE22: Host drives the timing select during master reset; low means async.
// RULE23: Pointers cross between sides in Gray code through two-stage synchronisers.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ffsf_status_flags (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire ffsf_pkg::ffsf_bus_t busReq,
  output var  logic [31:0]        rdData_q,
  input  wire logic               wrTick,
  input  wire logic               rdTick,
  input  wire logic               writeEnable_n,
  input  wire logic               readEnable_n,
  input  wire logic               masterReset_n,
  input  wire logic               partialReset_n,
  input  wire logic               fallThroughMode,
  input  wire logic               flagTimingSelect,
  output var  logic               noRoom_n_q,
  output var  logic               acceptReady_n_q,
  output var  logic               nothingStored_n_q,
  output var  logic               dataShown_n_q,
  output var  logic               almostFull_n_q,
  output var  logic               almostEmpty_n_q,
  output var  logic               halfLevel_n_q
);
  import ffsf_pkg::*;

  function automatic ffsf_ptr_t bin2gray(input ffsf_ptr_t b);
    return b ^ (b >> 1);
  endfunction

  function automatic ffsf_ptr_t gray2bin(input ffsf_ptr_t g);
    ffsf_ptr_t b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic      ftMode_q;
  logic      syncTiming_q;
  ffsf_ptr_t fullOfs_q;
  ffsf_ptr_t emptyOfs_q;
  ffsf_ptr_t wrPtr_q;
  ffsf_ptr_t wrGray_q;
  ffsf_ptr_t rdPtr_q;
  ffsf_ptr_t rdGray_q;
  logic      outValid_q;
  ffsf_ptr_t rdSync1_q;
  ffsf_ptr_t rdSync2_q;
  ffsf_ptr_t wrSync1_q;
  ffsf_ptr_t wrSync2_q;

  logic      inReset;
  logic      fullNow;
  logic      wrAccept;
  ffsf_ptr_t wrPtr_d;
  ffsf_ptr_t capacity;
  ffsf_ptr_t wrCnt_d;
  ffsf_ptr_t ramCnt;
  logic      ramHasData;
  logic      stdRead;
  logic      ftLoad;
  logic      trueRead;
  ffsf_ptr_t rdPtr_d;
  logic      outValid_d;
  ffsf_ptr_t consumed_d;
  ffsf_ptr_t rdCnt_d;
  ffsf_ptr_t trueCnt_d;
  ffsf_ptr_t fullThr;
  ffsf_ptr_t emptyThr;
  ffsf_ptr_t halfThr;

  assign inReset = !masterReset_n || !partialReset_n;

  // Capacity counts the output register in fall-through mode
  assign capacity = ftMode_q ? DEPTH + ONE_WORD : DEPTH;                             // RULE5
  assign fullThr  = capacity - fullOfs_q;                                            // RULE11 RULE12
  assign emptyThr = ftMode_q ? emptyOfs_q + ONE_WORD : emptyOfs_q;                   // RULE14 RULE15
  assign halfThr  = ftMode_q ? HALF_DEPTH + ONE_WORD : HALF_DEPTH;                   // RULE18 RULE19

  // Write side
  assign fullNow  = ftMode_q ? acceptReady_n_q : !noRoom_n_q;
  assign wrAccept = wrTick && !writeEnable_n && !fullNow;                            // RULE20
  assign wrPtr_d  = wrAccept ? wrPtr_q + ONE_WORD : wrPtr_q;
  assign wrCnt_d  = wrPtr_d - gray2bin(rdSync2_q);

  // Read side: sync stage two feeds the memory occupancy seen by reads
  assign ramCnt     = gray2bin(wrSync2_q) - rdPtr_q;
  assign ramHasData = ramCnt != '0;
  assign stdRead    = !ftMode_q && rdTick && !readEnable_n && ramHasData;            // RULE7
  assign ftLoad     = ftMode_q && rdTick && ramHasData && (!outValid_q || !readEnable_n); // RULE21
  assign trueRead   = rdTick && !readEnable_n;
  assign rdPtr_d    = (stdRead || ftLoad) ? rdPtr_q + ONE_WORD : rdPtr_q;

  always_comb begin
    outValid_d = outValid_q;
    if (ftLoad) begin
      outValid_d = 1'b1;
    end else if (ftMode_q && trueRead) begin
      outValid_d = 1'b0;                                                             // RULE9
    end
  end

  // Words not yet taken by the host; the held output word still counts
  assign consumed_d = rdPtr_d - {{(PTR_W-1){1'b0}}, outValid_d};                     // RULE5
  assign rdCnt_d    = gray2bin(wrSync1_q) - consumed_d;
  assign trueCnt_d  = wrPtr_d - consumed_d;

  // Modes are straps caught while master reset is held
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ftMode_q     <= 1'b0;
      syncTiming_q <= 1'b0;
    end else if (!masterReset_n) begin
      ftMode_q     <= fallThroughMode;
      syncTiming_q <= flagTimingSelect;                                              // RULE22
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q  <= '0;
      wrGray_q <= '0;
    end else if (inReset) begin
      wrPtr_q  <= '0;
      wrGray_q <= '0;
    end else if (wrTick) begin
      wrPtr_q  <= wrPtr_d;
      wrGray_q <= bin2gray(wrPtr_d);                                                 // RULE23
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr_q    <= '0;
      rdGray_q   <= '0;
      outValid_q <= 1'b0;
    end else if (inReset) begin
      rdPtr_q    <= '0;
      rdGray_q   <= '0;
      outValid_q <= 1'b0;
    end else if (rdTick) begin
      rdPtr_q    <= rdPtr_d;
      rdGray_q   <= bin2gray(consumed_d);                                            // RULE23
      outValid_q <= outValid_d;
    end
  end

  // Gray pointers cross on the receiving side's ticks only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdSync1_q <= '0;
      rdSync2_q <= '0;
    end else if (inReset) begin
      rdSync1_q <= '0;
      rdSync2_q <= '0;
    end else if (wrTick) begin
      rdSync1_q <= rdGray_q;                                                         // RULE23
      rdSync2_q <= rdSync1_q;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrSync1_q <= '0;
      wrSync2_q <= '0;
    end else if (inReset) begin
      wrSync1_q <= '0;
      wrSync2_q <= '0;
    end else if (rdTick) begin
      wrSync1_q <= wrGray_q;                                                         // RULE23
      wrSync2_q <= wrSync1_q;
    end
  end

  // Full / input-ready flag: the inactive function idles at its not-full level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      noRoom_n_q      <= 1'b1;
      acceptReady_n_q <= 1'b0;
    end else if (inReset) begin
      noRoom_n_q      <= 1'b1;
      acceptReady_n_q <= 1'b0;
    end else if (wrTick) begin                                                       // RULE6
      noRoom_n_q      <= ftMode_q || (wrCnt_d < capacity);                           // RULE1 RULE2
      acceptReady_n_q <= ftMode_q && (wrCnt_d >= capacity);                          // RULE3 RULE4
    end
  end

  // Empty / output-ready flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nothingStored_n_q <= 1'b0;
      dataShown_n_q     <= 1'b1;
    end else if (inReset) begin
      nothingStored_n_q <= 1'b0;
      dataShown_n_q     <= 1'b1;
    end else if (rdTick) begin                                                       // RULE10
      nothingStored_n_q <= !ftMode_q && (gray2bin(wrSync1_q) != rdPtr_d);            // RULE7
      dataShown_n_q     <= !outValid_d;                                              // RULE8 RULE21
    end
  end

  // Almost-full: async mode sets from write, releases from read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      almostFull_n_q <= 1'b1;
    end else if (inReset) begin
      almostFull_n_q <= 1'b1;
    end else if (syncTiming_q) begin
      if (wrTick) begin
        almostFull_n_q <= wrCnt_d < fullThr;                                         // RULE13
      end
    end else if (wrTick && trueCnt_d >= fullThr) begin
      almostFull_n_q <= 1'b0;                                                        // RULE13
    end else if (rdTick && trueCnt_d < fullThr) begin
      almostFull_n_q <= 1'b1;
    end
  end

  // Almost-empty: async mode sets from read, releases from write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      almostEmpty_n_q <= 1'b0;
    end else if (inReset) begin
      almostEmpty_n_q <= 1'b0;
    end else if (syncTiming_q) begin
      if (rdTick) begin
        almostEmpty_n_q <= rdCnt_d > emptyThr;                                       // RULE16
      end
    end else if (rdTick && trueCnt_d <= emptyThr) begin
      almostEmpty_n_q <= 1'b0;                                                       // RULE16
    end else if (wrTick && trueCnt_d > emptyThr) begin
      almostEmpty_n_q <= 1'b1;
    end
  end

  // Half flag is set and cleared by opposite sides, hence asynchronous
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      halfLevel_n_q <= 1'b1;
    end else if (inReset) begin
      halfLevel_n_q <= 1'b1;
    end else if (wrTick && trueCnt_d > halfThr) begin
      halfLevel_n_q <= 1'b0;                                                         // RULE17
    end else if (rdTick && trueCnt_d <= halfThr) begin
      halfLevel_n_q <= 1'b1;                                                         // RULE17
    end
  end

  // Offset registers survive partial reset; master reset restores defaults
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fullOfs_q  <= FULL_OFS_RST;
      emptyOfs_q <= EMPTY_OFS_RST;
    end else if (!masterReset_n) begin
      fullOfs_q  <= FULL_OFS_RST;
      emptyOfs_q <= EMPTY_OFS_RST;
    end else if (busReq.wr) begin
      if (busReq.addr == REG_FULL_OFS) begin
        fullOfs_q <= busReq.wdata[PTR_W-1:0];
      end
      if (busReq.addr == REG_EMPTY_OFS) begin
        emptyOfs_q <= busReq.wdata[PTR_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= '0;
    end else if (busReq.rd) begin
      rdData_q <= '0;
      unique case (busReq.addr)
        REG_FULL_OFS:  rdData_q[PTR_W-1:0] <= fullOfs_q;
        REG_EMPTY_OFS: rdData_q[PTR_W-1:0] <= emptyOfs_q;
        REG_STATUS: begin
          rdData_q[ST_NO_ROOM]     <= ftMode_q ? acceptReady_n_q : noRoom_n_q;
          rdData_q[ST_NOTHING]     <= ftMode_q ? dataShown_n_q : nothingStored_n_q;
          rdData_q[ST_ALMOST_FULL] <= almostFull_n_q;
          rdData_q[ST_ALMOST_EMPT] <= almostEmpty_n_q;
          rdData_q[ST_HALF]        <= halfLevel_n_q;
          rdData_q[ST_FT_MODE]     <= ftMode_q;
          rdData_q[ST_SYNC_TIMING] <= syncTiming_q;
          rdData_q[ST_OUT_VALID]   <= outValid_q;
        end
        REG_LEVEL:     rdData_q[PTR_W-1:0] <= wrPtr_q - gray2bin(rdSync2_q);
        default:       rdData_q <= '0;
      endcase
    end else begin
      rdData_q <= '0;
    end
  end

  // Checks
  logic runPrev_q;
  logic wrSideMove;
  logic halfSetNow;
  assign wrSideMove = wrTick || inReset;
  assign halfSetNow = wrTick && (trueCnt_d > halfThr);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      runPrev_q <= 1'b0;
    end else begin
      runPrev_q <= !inReset;
    end
  end
  sequence sWriteAtFull;
    !inReset && wrTick && !writeEnable_n && fullNow;
  endsequence

  chk_full_ignores_write: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE20
    sWriteAtFull |=> $stable(wrPtr_q))
    else $error("write taken while full");
  chk_full_after_depth: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
    (!inReset && !ftMode_q && wrAccept && wrCnt_d == DEPTH) |=> !noRoom_n_q)
    else $error("no room flag missed at depth");
  chk_ready_after_depth: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE4
    (!inReset && ftMode_q && wrAccept && wrCnt_d == DEPTH + ONE_WORD) |=> acceptReady_n_q)
    else $error("accept ready flag missed at depth plus one");
  chk_full_on_wtick: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE6
    ($changed(noRoom_n_q) || $changed(acceptReady_n_q)) |-> $past(wrSideMove))
    else $error("full flag moved without write tick");
  chk_empty_blocks_read: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE7
    (!inReset && !ftMode_q && !nothingStored_n_q && ramCnt == '0 && rdTick) |=> $stable(rdPtr_q))
    else $error("read taken while empty");
  chk_shown_rise_read: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE9
    ($rose(dataShown_n_q) && runPrev_q) |-> $past(trueRead))
    else $error("data shown flag rose without a read");
  chk_shown_tracks_word: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE8
    (ftMode_q && $rose(outValid_q)) |-> !dataShown_n_q)
    else $error("data shown flag late for first word");
  chk_afull_edges: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE13
    ($fell(almostFull_n_q) |-> $past(wrTick)) and
    ((syncTiming_q && $rose(almostFull_n_q) && runPrev_q) |-> $past(wrTick)))
    else $error("almost full flag moved on wrong side");
  chk_aempty_edges: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
    ($fell(almostEmpty_n_q) && runPrev_q) |-> $past(rdTick))
    else $error("almost empty flag set on wrong side");
  chk_half_edges: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE17
    ($fell(halfLevel_n_q) |-> $past(halfSetNow)) and
    (($rose(halfLevel_n_q) && runPrev_q) |-> $past(rdTick)))
    else $error("half level flag moved on wrong side");
endmodule
`default_nettype wire

// file: tb/ffsf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ffsf_host_model (
  input  wire logic core_clk,
  output var  logic wrTick,
  output var  logic rdTick,
  output var  logic writeEnable_n,
  output var  logic readEnable_n,
  output var  logic masterReset_n,
  output var  logic partialReset_n,
  output var  logic fallThroughMode,
  output var  logic flagTimingSelect
);
  initial begin
    wrTick = 1'b0;
    rdTick = 1'b0;
    writeEnable_n = 1'b1;
    readEnable_n = 1'b1;
    masterReset_n = 1'b1;
    partialReset_n = 1'b1;
    fallThroughMode = 1'b0;
    flagTimingSelect = 1'b0;
  end

  // Straps turn over after release, so a design that does not latch them shows it
  task automatic master_reset(input logic ftMode, input logic syncTiming);
    @(posedge core_clk);
    masterReset_n <= 1'b0;
    fallThroughMode <= ftMode;
    flagTimingSelect <= syncTiming;
    repeat (2) @(posedge core_clk);
    masterReset_n <= 1'b1;
    @(posedge core_clk);
    fallThroughMode <= ~ftMode;
    flagTimingSelect <= ~syncTiming;
  endtask

  task automatic partial_reset;
    @(posedge core_clk);
    partialReset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    partialReset_n <= 1'b1;
  endtask

  // Back-to-back transfers keep the tick high rather than re-raising it
  task automatic write_n(input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge core_clk);
      wrTick <= 1'b1;
      writeEnable_n <= 1'b0;
    end
    @(posedge core_clk);
    wrTick <= 1'b0;
    writeEnable_n <= 1'b1;
  endtask

  task automatic read_n(input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge core_clk);
      rdTick <= 1'b1;
      readEnable_n <= 1'b0;
    end
    @(posedge core_clk);
    rdTick <= 1'b0;
    readEnable_n <= 1'b1;
  endtask

  task automatic rd_pulse(input logic renN);
    @(posedge core_clk);
    rdTick <= 1'b1;
    readEnable_n <= renN;
    @(posedge core_clk);
    rdTick <= 1'b0;
    readEnable_n <= 1'b1;
  endtask

  // Clock edges on both sides with no transfer, to move pointers across
  task automatic idle(input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge core_clk);
      wrTick <= 1'b1;
      rdTick <= 1'b1;
    end
    @(posedge core_clk);
    wrTick <= 1'b0;
    rdTick <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/ffsf_status_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ffsf_status_flags_tb;
  import ffsf_pkg::*;
  logic        core_clk;
  logic        arst_n;
  ffsf_bus_t   busReq;
  logic [31:0] rdData_q;
  logic        wrTick;
  logic        rdTick;
  logic        writeEnable_n;
  logic        readEnable_n;
  logic        masterReset_n;
  logic        partialReset_n;
  logic        fallThroughMode;
  logic        flagTimingSelect;
  logic        noRoom_n_q;
  logic        acceptReady_n_q;
  logic        nothingStored_n_q;
  logic        dataShown_n_q;
  logic        almostFull_n_q;
  logic        almostEmpty_n_q;
  logic        halfLevel_n_q;
  int          fails;
  int          n_compared;
  int          wrCount;

  always #5 core_clk = ~core_clk;

  ffsf_host_model host (.core_clk(core_clk), .wrTick(wrTick), .rdTick(rdTick),
    .writeEnable_n(writeEnable_n), .readEnable_n(readEnable_n), .masterReset_n(masterReset_n),
    .partialReset_n(partialReset_n), .fallThroughMode(fallThroughMode),
    .flagTimingSelect(flagTimingSelect));

  ffsf_status_flags dut (.core_clk(core_clk), .arst_n(arst_n), .busReq(busReq), .rdData_q(rdData_q),
    .wrTick(wrTick), .rdTick(rdTick), .writeEnable_n(writeEnable_n), .readEnable_n(readEnable_n),
    .masterReset_n(masterReset_n), .partialReset_n(partialReset_n), .fallThroughMode(fallThroughMode),
    .flagTimingSelect(flagTimingSelect), .noRoom_n_q(noRoom_n_q), .acceptReady_n_q(acceptReady_n_q),
    .nothingStored_n_q(nothingStored_n_q), .dataShown_n_q(dataShown_n_q),
    .almostFull_n_q(almostFull_n_q), .almostEmpty_n_q(almostEmpty_n_q), .halfLevel_n_q(halfLevel_n_q));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t check %0d seen %h expected %h", $time, n_compared, seen, exp);
    end
  endtask

  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busReq.wr <= 1'b1;
    busReq.addr <= a;
    busReq.wdata <= d;
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic bus_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge core_clk);
    busReq.rd <= 1'b1;
    busReq.addr <= a;
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1;
    chk(rdData_q & mask, exp);
  endtask

  task automatic wr_to(input int t);
    host.write_n(t - wrCount);
    wrCount = t;
    settle();
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #600000;
    fails++;
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    busReq = '0;
    fails = 0;
    n_compared = 0;
    wrCount = 0;
    repeat (8) @(posedge core_clk);
    #1;
    chk({noRoom_n_q, nothingStored_n_q, almostFull_n_q, almostEmpty_n_q, halfLevel_n_q}, 5'h15);
    @(posedge core_clk);
    arst_n <= 1'b1;
    host.master_reset(1'b0, 1'b0);
    bus_chk(REG_FULL_OFS, {21'h0, FULL_OFS_RST}, '1);
    bus_chk(4'h2, 32'h0, '1);
    bus_wr(REG_FULL_OFS, 32'h10);
    bus_wr(REG_EMPTY_OFS, 32'hFFFFFFFF);
    bus_chk(REG_EMPTY_OFS, 32'h7FF, '1);
    bus_wr(REG_EMPTY_OFS, 32'h3);
    bus_chk(REG_FULL_OFS, 32'h10, '1);
    $display("Test registers done");
    wr_to(3);
    chk(almostEmpty_n_q, 1'b0);
    chk(nothingStored_n_q, 1'b0);
    wr_to(4);
    chk(almostEmpty_n_q, 1'b1);
    host.rd_pulse(1'b1);
    settle();
    chk(nothingStored_n_q, 1'b0);
    host.rd_pulse(1'b1);
    settle();
    chk(nothingStored_n_q, 1'b1);
    wr_to(512);
    chk(halfLevel_n_q, 1'b1);
    wr_to(513);
    chk(halfLevel_n_q, 1'b0);
    wr_to(1007);
    chk(almostFull_n_q, 1'b1);
    wr_to(1008);
    chk(almostFull_n_q, 1'b0);
    wr_to(1023);
    chk(noRoom_n_q, 1'b1);
    wr_to(1024);
    chk(noRoom_n_q, 1'b0);
    wr_to(1025);
    bus_chk(REG_LEVEL, 32'h400, '1);
    bus_chk(REG_STATUS, 32'h0A, 32'h7F);
    host.read_n(16);
    settle();
    chk(almostFull_n_q, 1'b0);
    host.read_n(1);
    settle();
    chk(almostFull_n_q, 1'b1);
    chk(noRoom_n_q, 1'b0);
    host.idle(3);
    settle();
    chk(noRoom_n_q, 1'b1);
    host.read_n(494);
    settle();
    chk(halfLevel_n_q, 1'b0);
    host.read_n(1);
    settle();
    chk(halfLevel_n_q, 1'b1);
    $display("Test standard mode done");
    host.partial_reset();
    settle();
    chk(nothingStored_n_q, 1'b0);
    bus_chk(REG_LEVEL, 32'h0, '1);
    bus_chk(REG_FULL_OFS, 32'h10, '1);
    $display("Test partial reset done");
    host.master_reset(1'b1, 1'b1);
    settle();
    chk(acceptReady_n_q, 1'b0);
    bus_chk(REG_FULL_OFS, {21'h0, FULL_OFS_RST}, '1);
    wrCount = 0;
    wr_to(1);
    host.rd_pulse(1'b1);
    settle();
    host.rd_pulse(1'b1);
    settle();
    chk(dataShown_n_q, 1'b1);
    host.rd_pulse(1'b1);
    settle();
    chk(dataShown_n_q, 1'b0);
    host.rd_pulse(1'b1);
    settle();
    chk(dataShown_n_q, 1'b0);
    chk(almostEmpty_n_q, 1'b0);
    host.rd_pulse(1'b0);
    settle();
    chk(dataShown_n_q, 1'b1);
    wrCount = 0;
    wr_to(128);
    host.idle(3);
    settle();
    chk(almostEmpty_n_q, 1'b0);
    wr_to(129);
    chk(almostEmpty_n_q, 1'b0);
    host.idle(3);
    settle();
    chk(almostEmpty_n_q, 1'b1);
    wr_to(513);
    chk(halfLevel_n_q, 1'b1);
    wr_to(514);
    chk(halfLevel_n_q, 1'b0);
    wr_to(897);
    chk(almostFull_n_q, 1'b1);
    wr_to(898);
    chk(almostFull_n_q, 1'b0);
    wr_to(1024);
    chk(acceptReady_n_q, 1'b0);
    wr_to(1025);
    chk(acceptReady_n_q, 1'b1);
    wr_to(1026);
    chk(acceptReady_n_q, 1'b1);
    bus_chk(REG_LEVEL, 32'h401, '1);
    bus_chk(REG_STATUS, 32'hE9, 32'hFF);
    $display("Test fall-through mode done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
